// ==== pll_clock_distribution_control.sv ====
// Control logic of a PLL clock network manager: source select, skewed
// dividers for eight banks and feedback, gating, power-down and lock.
// Assumes pins are asynchronous and the control clock models the VCO.
`timescale 1ns/1ps
module pll_clock_distribution_control
  import pll_dist_pkg::*;
#(
  parameter bit MID_IS_DIV1 = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire tpin_t ref_select_i,
  input wire tpin_t test_mode_i,
  input wire tpin_t vco_range_select_i,
  input wire tpin_t reset_divide_i,
  input wire div_pins_t feedback_divide_code_i,
  input wire ph_pins_t feedback_phase_code_i,
  input wire div_pins_t [NUM_BANKS-1:0] divider_code_i,
  input wire ph_pins_t [NUM_BANKS-1:0] bank_phase_code_i,
  input wire logic sync_output_gate_n_i,
  input wire logic crystal_osc_in_i,
  input wire logic ref_clock_i,
  input wire logic diff_ref_pos_i,
  input wire logic diff_ref_neg_i,
  input wire logic feedback_clock_in_i,
  output logic crystal_osc_out_o,
  output logic [NUM_BANKS-1:0][1:0] bank_clk_o,
  output logic [NUM_BANKS-1:0][1:0] bank_oe_o,
  output logic feedback_clock_out_o,
  output logic lock_o
);

  function automatic tern_t tern(input tpin_t p);
    unique case (p)
      PIN_LOW: tern = T_LOW;
      PIN_HIGH: tern = T_HIGH;
      default: tern = T_MID;
    endcase
  endfunction

  function automatic logic [6:0] trits(input div_pins_t d);
    logic [6:0] v;
    v = 7'h00;
    for (int i = 3; i >= 0; i--) begin
      v = 7'(v * 7'h03) + {5'h00, tern(d[i])};
    end
    trits = v;
  endfunction

  function automatic div_cfg_t div_dec(input div_pins_t d);
    logic [6:0] v;
    div_cfg_t r;
    v = trits(d);
    r = '{mode: OUT_CLOCK, inv: 1'b0, div: 6'h01};
    if (v <= DIV_NORM_LAST) begin
      r.div = 6'(v + 7'h01);
    end else if (v <= DIV_INV_LAST) begin
      r.div = 6'(v - DIV_NORM_LAST);
      r.inv = 1'b1;
    end else if (v == CODE_FORCE_LO) begin
      r.mode = OUT_LOW;
    end else if (v == CODE_FORCE_HI) begin
      r.mode = OUT_HIGH;
    end else begin
      r.mode = OUT_HIZ;
    end
    div_dec = r;
  endfunction

  function automatic shift_t ph_dec(input ph_pins_t p,
                                    input ph_kind_t kind,
                                    input logic wide);
    logic [6:0] v;
    shift_t t;
    v = trits({PIN_LOW, p});
    t = '0;
    unique case (kind)
      KIND_ODD: if (v < PH_ODD_N) t = PH_ODD[v[3:0]];
      KIND_EVEN: if (v < PH_EVEN_N) t = PH_EVEN[v[3:0]];
      default: if (v < PH_FB_N) t = PH_FB[v[3:0]];
    endcase
    ph_dec = wide ? shift_t'(t <<< 1) : t;
  endfunction

  function automatic logic [1:0] addr_dec(input logic [11:0] a);
    addr_dec = {a == ADDR_STATUS, a == ADDR_CTRL};
  endfunction

  // Two-stage capture of every pin
  pins_t pins_raw, sync1_reg, sync2_reg;
  assign pins_raw = '{ref_sel: ref_select_i, test: test_mode_i,
    range: vco_range_select_i, rst_div: reset_divide_i,
    fb_div: feedback_divide_code_i, fb_ph: feedback_phase_code_i,
    bank_div: divider_code_i, bank_ph: bank_phase_code_i,
    gate_n: sync_output_gate_n_i, xtal: crystal_osc_in_i,
    ref_in: ref_clock_i, diff_p: diff_ref_pos_i,
    diff_n: diff_ref_neg_i, fb: feedback_clock_in_i};

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  tern_t sel_t, test_t, range_t, rstdiv_t;
  assign sel_t = tern(sync2_reg.ref_sel);
  assign test_t = tern(sync2_reg.test);
  assign range_t = tern(sync2_reg.range);
  assign rstdiv_t = tern(sync2_reg.rst_div);

  logic ref_lvl, fb_lvl, div1;
  always_comb begin
    unique case (sel_t)
      T_LOW: ref_lvl = sync2_reg.xtal;
      T_MID: ref_lvl = sync2_reg.ref_in;
      T_HIGH: ref_lvl = sync2_reg.diff_p & ~sync2_reg.diff_n;
      default: ref_lvl = 1'b0;
    endcase
  end
  assign fb_lvl = sync2_reg.fb;
  assign div1 = (rstdiv_t == T_MID) ? MID_IS_DIV1 : ~MID_IS_DIV1;

  // Edge, detector, lock and sequencing state
  pll_state_t state_reg, state_next;
  logic ref_d_reg, ref_d_next, fb_d_reg, fb_d_next;
  logic half_reg, half_next, up_reg, up_next, dn_reg, dn_next;
  logic lock_reg, lock_next, xout_reg, xout_next;
  logic [7:0] ref_age_reg, ref_age_next, fb_age_reg, fb_age_next;
  logic [3:0] good_reg, good_next;
  logic ref_edge, fb_edge, ref_tick, ref_absent, fb_absent;
  logic [7:0] win;
  logic align_load;
  logic [1:0] step;

  assign ref_edge = ref_lvl & ~ref_d_reg;
  assign fb_edge = fb_lvl & ~fb_d_reg;
  assign ref_tick = ref_edge & (div1 | half_reg);
  assign ref_absent = ref_age_reg == ABSENT_CYC;
  assign fb_absent = fb_age_reg == ABSENT_CYC;
  assign win = (range_t == T_HIGH) ? LOCK_WIN_HI : LOCK_WIN_LM;

  always_comb begin
    ref_d_next = ref_lvl;
    fb_d_next = fb_lvl;
    half_next = ref_edge ? ~half_reg : half_reg;
    ref_age_next = ref_tick ? 8'h00 :
      (ref_absent ? ref_age_reg : ref_age_reg + 8'h01);
    fb_age_next = fb_edge ? 8'h00 :
      (fb_absent ? fb_age_reg : fb_age_reg + 8'h01);
    xout_next = ~sync2_reg.xtal;
    up_next = 1'b0;
    dn_next = 1'b0;
    good_next = good_reg;
    if (state_reg != ST_RUN || test_t != T_LOW || ref_absent ||
        fb_absent) begin
      good_next = 4'h0;
    end else if (fb_edge) begin
      if (ref_tick || ref_age_reg <= win) begin
        good_next = (good_reg == LOCK_COUNT) ? good_reg :
          good_reg + 4'h1;
      end else begin
        good_next = 4'h0;
        // Reference nearer behind than ahead: feedback is late
        up_next = ref_age_reg < (fb_age_reg >> 1);
        dn_next = ref_age_reg >= (fb_age_reg >> 1);
      end
    end
    lock_next = good_next == LOCK_COUNT;
    state_next = state_reg;
    unique case (state_reg)
      ST_DOWN: if (rstdiv_t != T_LOW) state_next = ST_ALIGN;
      ST_ALIGN: begin
        if (rstdiv_t == T_LOW) state_next = ST_DOWN;
        else if (ref_tick || ref_absent) state_next = ST_RUN;
      end
      ST_RUN: if (rstdiv_t == T_LOW) state_next = ST_DOWN;
      default: state_next = ST_DOWN;
    endcase
  end

  assign align_load = state_reg == ST_ALIGN && state_next == ST_RUN;

  always_comb begin
    if (state_reg != ST_RUN || test_t != T_LOW) begin
      step = 2'h0;
    end else begin
      // Missing clock leaves up/down idle: nominal midpoint rate
      step = 2'h1 + {1'b0, up_reg} - {1'b0, dn_reg};
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_DOWN;
      ref_d_reg <= 1'b0;
      fb_d_reg <= 1'b0;
      half_reg <= 1'b0;
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      lock_reg <= 1'b0;
      xout_reg <= 1'b0;
      ref_age_reg <= ABSENT_CYC;
      fb_age_reg <= ABSENT_CYC;
      good_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      ref_d_reg <= ref_d_next;
      fb_d_reg <= fb_d_next;
      half_reg <= half_next;
      up_reg <= up_next;
      dn_reg <= dn_next;
      lock_reg <= lock_next;
      xout_reg <= xout_next;
      ref_age_reg <= ref_age_next;
      fb_age_reg <= fb_age_next;
      good_reg <= good_next;
    end
  end

  // Register slave: bank enable mask and status
  logic [NUM_BANKS-1:0] ctrl_reg, ctrl_next;
  logic [31:0] prdata_reg, prdata_next;
  logic slverr_reg, slverr_next;
  status_t status;
  assign status = '{state: state_reg, ref_absent: ref_absent,
    fb_absent: fb_absent, range: range_t, test: test_t, ref_sel: sel_t,
    div1: div1, lock: lock_reg};

  always_comb begin
    ctrl_next = ctrl_reg;
    prdata_next = prdata_reg;
    slverr_next = slverr_reg;
    if (psel_i && !penable_i) begin
      slverr_next = addr_dec(paddr_i) == 2'h0;
      prdata_next = '0;
      if (addr_dec(paddr_i) == 2'h2) prdata_next = 32'(status);
      if (addr_dec(paddr_i) == 2'h1 && !pwrite_i) begin
        prdata_next = 32'(ctrl_reg);
      end
    end
    if (psel_i && penable_i && pwrite_i && addr_dec(paddr_i) == 2'h1) begin
      ctrl_next = pwdata_i[NUM_BANKS-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= CTRL_RESET;
      prdata_reg <= '0;
      slverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = 1'b1;
  assign pslverr_o = slverr_reg;

  // Output channels: banks 0..7, then feedback
  div_pins_t div_all [NUM_CHAN];
  ph_pins_t ph_all [NUM_CHAN];
  div_cfg_t cfg_all [NUM_CHAN];
  logic chan_clk [NUM_CHAN];
  logic chan_oe [NUM_CHAN];
  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      div_all[i] = sync2_reg.bank_div[i];
      ph_all[i] = sync2_reg.bank_ph[i];
    end
    div_all[NUM_BANKS] = sync2_reg.fb_div;
    ph_all[NUM_BANKS] = sync2_reg.fb_ph;
  end

  for (genvar c = 0; c < NUM_CHAN; c++) begin : chan
    localparam bit IS_FB = c == NUM_BANKS;
    localparam ph_kind_t KIND = IS_FB ? KIND_FB :
      ((c % 2 == 1) ? KIND_ODD : KIND_EVEN);
    div_cfg_t cfg;
    shift_t sh;
    logic [9:0] per, half, ld, cnt_reg, cnt_next;
    logic [10:0] sum;
    logic src, gated, enabled;
    logic clk_reg, clk_next, oe_reg, oe_next, gate_reg, gate_next;

    assign cfg = div_dec(div_all[c]);
    assign cfg_all[c] = cfg;
    assign sh = ph_dec(ph_all[c], KIND, range_t == T_HIGH);
    assign per = 10'(cfg.div * STEPS_PER_CYCLE);
    assign half = 10'(cfg.div * HALF_CYCLE);
    assign enabled = IS_FB ? 1'b1 : ctrl_reg[c % NUM_BANKS];
    assign gated = IS_FB ? 1'b1 : gate_reg;

    always_comb begin
      sum = {1'b0, cnt_reg} + {9'h000, step};
      if (sum >= {1'b0, per}) sum = sum - {1'b0, per};
      if (sum >= {1'b0, per}) sum = '0;
      // Start phase so that a positive shift delays the output
      ld = (sh > 0) ? per - {5'h00, sh} : {5'h00, -sh};
      cnt_next = align_load ? ld : sum[9:0];
      if (test_t == T_LOW) src = (cnt_reg < half) ^ cfg.inv;
      else if (test_t == T_MID) src = ref_lvl ^ cfg.inv;
      else src = fb_lvl ^ cfg.inv;
      // Gate changes only while the output is low: a pulse already high holds the gate, but one that rises as the gate closes is cut after one cycle
      gate_next = clk_reg ? gate_reg : !sync2_reg.gate_n;
      oe_next = enabled;
      clk_next = 1'b0;
      unique case (cfg.mode)
        OUT_CLOCK: clk_next = gated & src;
        OUT_LOW: clk_next = 1'b0;
        OUT_HIGH: clk_next = 1'b1;
        OUT_HIZ: oe_next = 1'b0;
      endcase
      if (!enabled || state_reg == ST_DOWN) begin
        clk_next = 1'b0;
        oe_next = 1'b0;
      end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        cnt_reg <= '0;
        clk_reg <= 1'b0;
        oe_reg <= 1'b0;
        gate_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_next;
        clk_reg <= clk_next;
        oe_reg <= oe_next;
        gate_reg <= gate_next;
      end
    end

    assign chan_clk[c] = clk_reg;
    assign chan_oe[c] = oe_reg;

    if (!IS_FB) begin : bank_chk
      a_forced_low: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        cfg.mode == OUT_LOW |=> !clk_reg)
        else $error("forced-low bank toggled");
    end else begin : fb_chk
      a_fb_ungated: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        state_reg == ST_RUN && test_t == T_LOW &&
        cfg.mode == OUT_CLOCK ##0 sync2_reg.gate_n
        |=> clk_reg == $past(src))
        else $error("feedback output gated");
    end
  end

  for (genvar b = 0; b < NUM_BANKS; b++) begin : pins_out
    assign bank_clk_o[b] = {2{chan_clk[b]}};
    assign bank_oe_o[b] = {2{chan_oe[b]}};
  end
  assign feedback_clock_out_o = chan_clk[NUM_BANKS];
  assign crystal_osc_out_o = xout_reg;
  assign lock_o = lock_reg;

  a_pd_fb_low: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    state_reg == ST_DOWN |=> !feedback_clock_out_o)
    else $error("feedback output not low in power-down");

  a_pd_banks_hiz: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    state_reg == ST_DOWN [*2] |-> bank_oe_o == '0)
    else $error("bank driven in power-down");

  a_lock_clean: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    ref_absent || fb_absent || state_reg != ST_RUN |=> !lock_o)
    else $error("lock without valid clocks");

  a_leave_down: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    state_reg == ST_DOWN && rstdiv_t != T_LOW |=> state_reg == ST_ALIGN)
    else $error("power-down exit skipped alignment");

  a_align_exit: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    state_reg == ST_ALIGN && rstdiv_t != T_LOW && ref_tick
    |=> state_reg == ST_RUN ##1 state_reg != ST_ALIGN)
    else $error("alignment did not release on reference edge");

  a_test_halts: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    test_t != T_LOW |-> step == 2'h0)
    else $error("oscillator advanced in test mode");

  a_ref_select: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    sel_t == T_LOW |-> ref_lvl == sync2_reg.xtal)
    else $error("crystal not selected");

  a_apb_unmapped: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    psel_i && !penable_i && addr_dec(paddr_i) == 2'h0
    |=> pslverr_o && prdata_o == '0)
    else $error("unmapped access not flagged");
endmodule

// ==== pll_dist_pkg.sv ====
// Constants, field layouts and types of the PLL clock distribution control
// Assumes one 100 MHz control clock; ternary pins come as two comparators
package pll_dist_pkg;
  localparam int CLK_PS = 10000;
  localparam int CLK_NS = 10;
  localparam int NUM_BANKS = 8;
  localparam int NUM_CHAN = NUM_BANKS + 1;
  localparam int STEPS_PER_CYCLE = 16;
  localparam int HALF_CYCLE = 8;
  localparam int LOCK_WIN_LM_PS = 2000;
  localparam int LOCK_WIN_HI_PS = 1500;
  localparam logic [7:0] LOCK_WIN_LM =
    8'((LOCK_WIN_LM_PS >= CLK_PS) ? LOCK_WIN_LM_PS / CLK_PS : 1);
  localparam logic [7:0] LOCK_WIN_HI =
    8'((LOCK_WIN_HI_PS >= CLK_PS) ? LOCK_WIN_HI_PS / CLK_PS : 1);
  localparam int ABSENT_NS = 2000;
  localparam logic [7:0] ABSENT_CYC = 8'(ABSENT_NS / CLK_NS);
  localparam logic [3:0] LOCK_COUNT = 4'h8;

  typedef logic [1:0] tpin_t;
  localparam tpin_t PIN_LOW = 2'h0;
  localparam tpin_t PIN_HIGH = 2'h3;
  typedef tpin_t [3:0] div_pins_t;
  typedef tpin_t [2:0] ph_pins_t;
  typedef enum logic [1:0] {T_LOW = 2'h0, T_MID = 2'h1,
    T_HIGH = 2'h2} tern_t;

  typedef enum logic [1:0] {OUT_CLOCK = 2'h0, OUT_LOW = 2'h1,
    OUT_HIGH = 2'h2, OUT_HIZ = 2'h3} out_mode_t;
  typedef struct packed {
    out_mode_t mode;
    logic inv;
    logic [5:0] div;
  } div_cfg_t;
  localparam logic [6:0] DIV_NORM_LAST = 7'h1F;
  localparam logic [6:0] DIV_INV_LAST = 7'h3F;
  localparam logic [6:0] CODE_FORCE_LO = 7'h48;
  localparam logic [6:0] CODE_FORCE_HI = 7'h4A;

  typedef enum logic [1:0] {KIND_ODD = 2'h0, KIND_EVEN = 2'h1,
    KIND_FB = 2'h2} ph_kind_t;
  typedef logic signed [4:0] shift_t;
  localparam logic [6:0] PH_ODD_N = 7'h09;
  localparam logic [6:0] PH_EVEN_N = 7'h09;
  localparam logic [6:0] PH_FB_N = 7'h0B;
  localparam shift_t PH_ODD [0:8] = '{5'sh1C, 5'sh1D, 5'sh1E, 5'sh1F,
    5'sh00, 5'sh01, 5'sh02, 5'sh03, 5'sh04};
  localparam shift_t PH_EVEN [0:8] = '{5'sh1A, 5'sh1C, 5'sh1E, 5'sh1F,
    5'sh00, 5'sh01, 5'sh02, 5'sh04, 5'sh06};
  localparam shift_t PH_FB [0:10] = '{5'sh1A, 5'sh1C, 5'sh1D, 5'sh1E,
    5'sh1F, 5'sh00, 5'sh01, 5'sh02, 5'sh03, 5'sh04, 5'sh06};

  typedef enum logic [1:0] {ST_DOWN = 2'h0, ST_ALIGN = 2'h1,
    ST_RUN = 2'h3} pll_state_t;

  typedef struct packed {
    tpin_t ref_sel;
    tpin_t test;
    tpin_t range;
    tpin_t rst_div;
    div_pins_t fb_div;
    ph_pins_t fb_ph;
    div_pins_t [NUM_BANKS-1:0] bank_div;
    ph_pins_t [NUM_BANKS-1:0] bank_ph;
    logic gate_n;
    logic xtal;
    logic ref_in;
    logic diff_p;
    logic diff_n;
    logic fb;
  } pins_t;

  typedef struct packed {
    pll_state_t state;
    logic ref_absent;
    logic fb_absent;
    tern_t range;
    tern_t test;
    tern_t ref_sel;
    logic div1;
    logic lock;
  } status_t;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [NUM_BANKS-1:0] CTRL_RESET = 8'hFF;
endpackage

// ==== far_side_clocks.sv ====
// Far side model: three reference sources and the feedback trace
// Assumes clk_i is the bench clock; sources step on its rising edge
`timescale 1ns/1ps
module far_side_clocks (
  input wire logic clk_i,
  input wire logic ref_run_i,
  input wire logic fb_loop_i,
  input wire logic feedback_clock_out_i,
  output logic crystal_osc_in_o,
  output logic ref_clock_o,
  output logic diff_ref_pos_o,
  output logic diff_ref_neg_o,
  output logic feedback_clock_in_o
);
  logic [7:0] cnt_reg = 8'h00;
  logic [7:0] held_reg = 8'h00;
  logic fb_reg = 1'b0;
  always @(posedge clk_i) begin
    cnt_reg <= cnt_reg + 8'h01;
    // Absent source stands still at its last level
    if (ref_run_i) begin
      held_reg <= cnt_reg;
    end
    // Trace delay of one cycle, or a free source of period 64
    fb_reg <= fb_loop_i ? feedback_clock_out_i : cnt_reg[5];
  end
  // All three sources toggle at once, at different rates
  assign crystal_osc_in_o = held_reg[3];
  assign ref_clock_o = held_reg[4];
  assign diff_ref_pos_o = held_reg[5];
  assign diff_ref_neg_o = ~held_reg[5];
  assign feedback_clock_in_o = fb_reg;
endmodule

// ==== tb_pll_clock_distribution_control.sv ====
// Self-checking bench for the PLL clock distribution control
// Assumes the package and far_side_clocks are compiled first
`timescale 1ns/1ps
module tb_pll_clock_distribution_control;
  import pll_dist_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o;
  tpin_t ref_select_i = 2'h1, test_mode_i = 2'h0;
  tpin_t vco_range_select_i = 2'h1, reset_divide_i = 2'h0;
  div_pins_t fb_div = 8'h01;
  ph_pins_t fb_ph = 6'h00;
  div_pins_t [NUM_BANKS-1:0] bank_div = '0;
  ph_pins_t [NUM_BANKS-1:0] bank_ph = '0;
  logic gate_n = 1'b0, ref_run = 1'b1, fb_loop = 1'b1;
  logic xtal, refc, dpos, dneg, fbin, feedback_clock_out, lock, xout;
  logic [NUM_BANKS-1:0][1:0] bank_clk, bank_oe;
  logic [9:0] watch;
  int failures = 0, check_count = 0, seed = 30429;

  always #(CLK_NS / 2) ref_clk_i = ~ref_clk_i;
  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      watch[i] = bank_clk[i][0];
    end
    watch[8] = feedback_clock_out;
    watch[9] = xout;
  end

  pll_clock_distribution_control dut (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ref_select_i(ref_select_i), .test_mode_i(test_mode_i),
    .vco_range_select_i(vco_range_select_i),
    .reset_divide_i(reset_divide_i), .feedback_divide_code_i(fb_div),
    .feedback_phase_code_i(fb_ph), .divider_code_i(bank_div),
    .bank_phase_code_i(bank_ph), .sync_output_gate_n_i(gate_n),
    .crystal_osc_in_i(xtal), .ref_clock_i(refc),
    .diff_ref_pos_i(dpos), .diff_ref_neg_i(dneg),
    .feedback_clock_in_i(fbin), .crystal_osc_out_o(xout),
    .bank_clk_o(bank_clk), .bank_oe_o(bank_oe),
    .feedback_clock_out_o(feedback_clock_out), .lock_o(lock));

  far_side_clocks partner (.clk_i(ref_clk_i), .ref_run_i(ref_run),
    .fb_loop_i(fb_loop), .feedback_clock_out_i(feedback_clock_out),
    .crystal_osc_in_o(xtal), .ref_clock_o(refc),
    .diff_ref_pos_o(dpos), .diff_ref_neg_o(dneg),
    .feedback_clock_in_o(fbin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input int tol);
    chk((got >= exp - tol && got <= exp + tol) ? exp : got, exp);
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'b1) @(posedge ref_clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  function automatic tpin_t tp(input int d);
    return (d == 0) ? PIN_LOW : (d == 1) ? 2'h1 : PIN_HIGH;
  endfunction

  function automatic div_pins_t dcode(input int v);
    div_pins_t r;
    for (int i = 0; i < 4; i++) begin
      r[i] = tp(v % 3);
      v = v / 3;
    end
    return r;
  endfunction

  // Model: divide value to bank period in control cycles
  function automatic int exp_per(input int v);
    return (v <= 31 ? v + 1 : v - 31) * STEPS_PER_CYCLE;
  endfunction

  task automatic edges(input int i, input int cyc, output int n);
    logic p;
    n = 0;
    p = watch[i];
    repeat (cyc) begin
      @(posedge ref_clk_i);
      if (watch[i] === 1'b1 && p === 1'b0) n++;
      p = watch[i];
    end
  endtask

  task automatic per(input int i, output int p);
    int n;
    n = 0;
    p = 0;
    while (n == 0 && p < 2000) begin
      edges(i, 1, n);
      p++;
    end
    p = 0;
    n = 0;
    while (n == 0 && p < 2000) begin
      edges(i, 1, n);
      p++;
    end
  endtask

  task automatic pd();
    @(posedge ref_clk_i);
    reset_divide_i <= PIN_LOW;
    repeat (8) @(posedge ref_clk_i);
  endtask

  task automatic go(input tpin_t lvl);
    @(posedge ref_clk_i);
    reset_divide_i <= lvl;
    repeat (150) @(posedge ref_clk_i);
  endtask

  task automatic set_bank(input int b, input int v, input int ph);
    div_pins_t [NUM_BANKS-1:0] t;
    div_pins_t d;
    t = '0;
    t[b] = dcode(v);
    d = dcode(ph);
    bank_div <= t;
    bank_ph[b] <= d[2:0];
  endtask

  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk_i);
    failures++;
    report_and_stop();
  end

  initial begin
    logic [31:0] rd;
    logic err;
    int n, v, b;
    tpin_t pc [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [1:0] te [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
    int vl [4] = '{0, 31, 32, 63};
    int dc [4] = '{72, 74, 80, 64};
    logic [3:0] de [4] = '{4'hC, 4'hF, 4'h0, 4'h0};
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
    chk(rd, {24'h0, CTRL_RESET});
    apb(1'b1, ADDR_CTRL, 32'h0000005A, rd, err);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
    chk(rd, 32'h0000005A);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk({rd[30:0], err}, 32'h00000001);
    apb(1'b1, ADDR_CTRL, 32'h000000FF, rd, err);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      ref_select_i <= pc[i];
      vco_range_select_i <= pc[(i + 1) % 4];
      test_mode_i <= pc[(i + 2) % 4];
      repeat (4) @(posedge ref_clk_i);
      apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
      chk(rd & 32'h00000CFC, {24'h0, te[(i + 1) % 4], te[(i + 2) % 4],
        te[i], 2'h0});
    end
    ref_select_i <= 2'h1;
    vco_range_select_i <= 2'h1;
    test_mode_i <= PIN_LOW;
    $display("test pin decode done");
    go(2'h1);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
    chk(rd & 32'h00000C02, 32'h00000C02);
    pd();
    chk({15'h0, feedback_clock_out, bank_oe}, 32'h0);
    edges(8, 40, n);
    chk(n, 0);
    go(PIN_HIGH);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
    chk(rd & 32'h00000C02, 32'h00000C00);
    $display("test power-down done");
    for (int k = 0; k < 6; k++) begin
      v = (k < 4) ? vl[k] : {$random(seed)} % 64;
      b = {$random(seed)} % NUM_BANKS;
      pd();
      set_bank(b, v, {$random(seed)} % 9);
      go(2'h1);
      per(b, n);
      near(n, exp_per(v), 1);
    end
    for (int k = 0; k < 4; k++) begin
      pd();
      set_bank(k * 2 + 1, dc[k], 4);
      go(2'h1);
      chk({bank_oe[k * 2 + 1], bank_clk[k * 2 + 1]}, de[k]);
    end
    $display("test dividers done");
    pd();
    set_bank(0, 0, 4);
    go(2'h1);
    gate_n <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    edges(0, 64, n);
    chk(n, 0);
    chk({bank_oe[0], bank_clk[0]}, 4'hC);
    edges(8, 64, n);
    near(n, 2, 1);
    repeat (200) @(posedge ref_clk_i);
    chk({31'h0, lock}, 32'h1);
    gate_n <= 1'b0;
    $display("test gating done");
    pd();
    test_mode_i <= 2'h1;
    go(2'h1);
    edges(0, 320, n);
    near(n, 10, 1);
    pd();
    test_mode_i <= PIN_HIGH;
    fb_loop <= 1'b0;
    go(2'h1);
    edges(0, 320, n);
    near(n, 5, 1);
    pd();
    test_mode_i <= PIN_LOW;
    fb_loop <= 1'b1;
    go(2'h1);
    $display("test modes done");
    ref_run <= 1'b0;
    repeat (260) @(posedge ref_clk_i);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
    chk(rd & 32'h00000201, 32'h00000200);
    chk({31'h0, lock}, 32'h0);
    edges(0, 64, n);
    near(n, 4, 1);
    ref_run <= 1'b1;
    edges(9, 64, n);
    near(n, 4, 1);
    $display("test reference loss done");
    report_and_stop();
  end
endmodule
